/* File: logic/twc_write_handler.sv */
// tape write command handler: decode, checks, data phase, buffer flushing
module twc_write_handler #(
  parameter int TICK_CYC = twc_pkg::DELAY_UNIT_CYC
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_we, // register write strobe
  input wire logic reg_re, // register read strobe
  output logic [31:0] reg_rdata, // read data, cycle after reg_re
  input wire logic host_valid, // initiator byte valid
  input wire logic [7:0] host_data, // initiator byte
  output logic host_ready, // byte taken when valid and ready
  output logic tape_wr, // pulse: tape_data into tape buffer
  output logic [7:0] tape_data, // byte toward tape buffer
  input wire logic tape_full, // tape buffer cannot take a byte
  input wire logic tape_idle, // all buffered data is on tape
  output logic flush_req, // pulse: write buffer to tape
  output logic logical_start_of_tape_pat_req, // pulse: record start-of-tape pattern
  input wire logic pattern_done, // pulse: start pattern recorded
  input wire logic pos_logical_start_of_tape, // tape at logical start
  input wire logic pos_fm_bot, // at start side of long filemark
  input wire logic pos_fm_eot, // at end side of long filemark
  input wire logic pos_eod, // at end-of-data mark
  input wire logic pos_blank, // at blank tape after data
  input wire logic cart_fmt_known, // cartridge holds recorded data
  input wire logic cart_fmt_new, // recorded data is newer format
  input wire logic unload_btn, // front panel unload button
  output logic bus_released, // bus released while unbuffered write drains to tape
  output logic cmd_done // pulse: command ended, status valid
);
  // configuration registers
  logic [7:0] cdb [0:5];
  logic [7:0] next_cdb [0:5];
  logic [7:0] modehdr, next_modehdr;
  logic [23:0] blklen, next_blklen;
  logic [3:0] opts, next_opts;
  logic [7:0] wdelay, next_wdelay;
  logic [23:0] motion, next_motion;
  logic [23:0] blkmin, next_blkmin;
  logic [23:0] blkmax, next_blkmax;
  logic locrev, next_locrev;
  logic go;
  logic [31:0] next_rdata;

  // command state
  twc_pkg::twc_state_t state, next_state;
  logic [23:0] byte_left, next_byte_left;
  logic [23:0] blk_left, next_blk_left;
  logic [23:0] pend, next_pend;
  logic [3:0] sense_key, next_sense_key;
  logic [7:0] asc, next_asc;
  logic [7:0] ascq, next_ascq;
  logic check, next_check;
  logic done_flag, next_done_flag;
  logic drain_wait, next_drain_wait;
  logic next_tape_wr;
  logic [7:0] next_tape_data;
  logic next_flush_req;
  logic next_logical_start_of_tape_pat_req;

  // button synchroniser and delay timer
  logic btn_s1, btn_s2, btn_s3, btn_lvl, btn_lvl_d;
  logic next_btn_lvl;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [7:0] dly_cnt, next_dly_cnt;
  logic tick, btn_evt, dly_evt;

  logic fixed, buffered, take;
  logic [23:0] xfer_len;
  logic mismatch, size_bad, pos_ok, fmt_bad;
  logic op_flush;

  assign go = reg_we && reg_addr == twc_pkg::A_CTRL
    && reg_wdata[twc_pkg::CTL_GO];
  assign fixed = cdb[1][twc_pkg::CDB1_FIXED];
  assign xfer_len = {cdb[2], cdb[3], cdb[4]};
  assign buffered = |modehdr[twc_pkg::MH_BUF_HI:twc_pkg::MH_BUF_LO];

  assign mismatch = fixed ? (blklen == 24'h000000)
    : (blklen != 24'h000000);
  assign size_bad = fixed ? (blklen < blkmin || blklen > blkmax)
    : (xfer_len > (opts[twc_pkg::OPT_ND] ? twc_pkg::VAR_MAX_ND
    : twc_pkg::VAR_MAX));
  assign pos_ok = pos_logical_start_of_tape || (opts[twc_pkg::OPT_NEWFMT]
    ? (pos_fm_bot || pos_fm_eot || pos_eod)
    : (pos_fm_bot || pos_blank));
  assign fmt_bad = !pos_logical_start_of_tape && cart_fmt_known
    && (cart_fmt_new != opts[twc_pkg::OPT_NEWFMT]);

  always_comb begin
    case (cdb[0])
      twc_pkg::OP_REWIND, twc_pkg::OP_SPACE, twc_pkg::OP_ERASE,
      twc_pkg::OP_LOAD: op_flush = 1'b1;
      twc_pkg::OP_WFM: op_flush = !cdb[1][twc_pkg::WFM_IMMED];
      // reverse bit arrives with the go write itself
      twc_pkg::OP_LOCATE: op_flush = reg_wdata[twc_pkg::CTL_LOCREV];
      default: op_flush = 1'b0;
    endcase
  end

  assign host_ready = state == twc_pkg::ST_XFER && !tape_full;
  assign take = host_ready && host_valid;
  assign bus_released = opts[twc_pkg::OPT_DISC]
    && state == twc_pkg::ST_DRAIN;
  assign cmd_done = state == twc_pkg::ST_FIN;

  // register file
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      next_cdb[i] = cdb[i];
    end
    next_modehdr = modehdr;
    next_blklen = blklen;
    next_opts = opts;
    next_wdelay = wdelay;
    next_motion = motion;
    next_blkmin = blkmin;
    next_blkmax = blkmax;
    next_locrev = locrev;
    next_rdata = 32'h00000000;
    if (reg_we && state == twc_pkg::ST_IDLE) begin
      if (reg_addr <= twc_pkg::A_CDB5 && reg_addr[1:0] == 2'b00) begin
        next_cdb[reg_addr[4:2]] = reg_wdata[7:0];
      end
      case (reg_addr)
        twc_pkg::A_CTRL: next_locrev = reg_wdata[twc_pkg::CTL_LOCREV];
        twc_pkg::A_MODEHDR: next_modehdr = reg_wdata[7:0];
        twc_pkg::A_BLKLEN: next_blklen = reg_wdata[23:0];
        twc_pkg::A_OPTS: next_opts = reg_wdata[3:0];
        twc_pkg::A_WDELAY: begin
          if (opts[twc_pkg::OPT_PF]) begin
            next_wdelay = reg_wdata[7:0];
          end
        end
        twc_pkg::A_MOTION: next_motion = reg_wdata[23:0];
        twc_pkg::A_BLKMIN: next_blkmin = reg_wdata[23:0];
        twc_pkg::A_BLKMAX: next_blkmax = reg_wdata[23:0];
        default: ;
      endcase
    end
    if (reg_re) begin
      if (reg_addr <= twc_pkg::A_CDB5 && reg_addr[1:0] == 2'b00) begin
        next_rdata = {24'h000000, cdb[reg_addr[4:2]]};
      end
      case (reg_addr)
        twc_pkg::A_CTRL: next_rdata = {30'h00000000, locrev, 1'b0};
        twc_pkg::A_MODEHDR: next_rdata = {24'h000000, modehdr};
        twc_pkg::A_BLKLEN: next_rdata = {8'h00, blklen};
        twc_pkg::A_OPTS: next_rdata = {28'h0000000, opts};
        twc_pkg::A_WDELAY: next_rdata = {24'h000000, wdelay};
        twc_pkg::A_MOTION: next_rdata = {8'h00, motion};
        twc_pkg::A_BLKMIN: next_rdata = {8'h00, blkmin};
        twc_pkg::A_BLKMAX: next_rdata = {8'h00, blkmax};
        twc_pkg::A_STATUS: next_rdata = {ascq, asc, sense_key, 9'h000,
          cmd_done || done_flag, check, state != twc_pkg::ST_IDLE};
        twc_pkg::A_PEND: next_rdata = {8'h00, pend};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 6; i++) begin
        cdb[i] <= 8'h00;
      end
      modehdr <= twc_pkg::MODEHDR_RST;
      blklen <= twc_pkg::BLKLEN_RST;
      opts <= twc_pkg::OPTS_RST;
      wdelay <= twc_pkg::WDELAY_RST;
      motion <= twc_pkg::MOTION_RST;
      blkmin <= twc_pkg::BLKMIN_RST;
      blkmax <= twc_pkg::BLKMAX_RST;
      locrev <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      for (int i = 0; i < 6; i++) begin
        cdb[i] <= next_cdb[i];
      end
      modehdr <= next_modehdr;
      blklen <= next_blklen;
      opts <= next_opts;
      wdelay <= next_wdelay;
      motion <= next_motion;
      blkmin <= next_blkmin;
      blkmax <= next_blkmax;
      locrev <= next_locrev;
      reg_rdata <= next_rdata;
    end
  end

  // command sequencer
  always_comb begin
    next_state = state;
    next_byte_left = byte_left;
    next_blk_left = blk_left;
    next_pend = pend;
    next_sense_key = sense_key;
    next_asc = asc;
    next_ascq = ascq;
    next_check = check;
    next_done_flag = done_flag;
    next_drain_wait = 1'b0;
    next_tape_wr = 1'b0;
    next_tape_data = tape_data;
    next_flush_req = 1'b0;
    next_logical_start_of_tape_pat_req = 1'b0;
    case (state)
      twc_pkg::ST_IDLE: begin
        if (go) begin
          next_check = 1'b0;
          next_done_flag = 1'b0;
          next_sense_key = twc_pkg::SK_GOOD;
          next_asc = 8'h00;
          next_ascq = 8'h00;
          if (cdb[0] == twc_pkg::OP_WRITE) begin
            next_state = twc_pkg::ST_CHECK;
          end else begin
            next_flush_req = op_flush;
            next_state = twc_pkg::ST_FIN;
          end
        end
      end
      twc_pkg::ST_CHECK: begin
        next_byte_left = fixed ? blklen : xfer_len;
        next_blk_left = fixed ? xfer_len : 24'h000001;
        next_state = twc_pkg::ST_FIN;
        if (mismatch) begin
          next_check = 1'b1;
          next_sense_key = twc_pkg::SK_ILLEGAL;
          next_asc = twc_pkg::ASC_MISMATCH;
          next_ascq = twc_pkg::ASCQ_MISMATCH;
        end else if (size_bad || !pos_ok || fmt_bad) begin
          next_check = 1'b1;
          next_sense_key = twc_pkg::SK_ILLEGAL;
          next_asc = twc_pkg::ASC_OTHER;
        end else if (xfer_len == 24'h000000) begin
          next_state = twc_pkg::ST_FIN;
        end else if (pos_logical_start_of_tape) begin
          next_logical_start_of_tape_pat_req = 1'b1;
          next_state = twc_pkg::ST_PATTERN;
        end else begin
          next_state = twc_pkg::ST_XFER;
        end
      end
      twc_pkg::ST_PATTERN: begin
        if (pattern_done) begin
          next_state = twc_pkg::ST_XFER;
        end
      end
      twc_pkg::ST_XFER: begin
        if (take) begin
          next_tape_wr = 1'b1;
          next_tape_data = host_data;
          next_pend = pend + 24'h000001;
          next_byte_left = byte_left - 24'h000001;
          if (byte_left == 24'h000001) begin
            next_blk_left = blk_left - 24'h000001;
            next_byte_left = blklen;
            if (blk_left == 24'h000001) begin
              if (buffered) begin
                next_state = twc_pkg::ST_FIN;
              end else begin
                next_flush_req = 1'b1;
                next_drain_wait = 1'b1;
                next_state = twc_pkg::ST_DRAIN;
              end
            end
          end
        end
        if (buffered && pend >= motion && pend != 24'h000000) begin
          next_flush_req = 1'b1;
        end
      end
      twc_pkg::ST_DRAIN: begin
        if (!drain_wait && tape_idle) begin
          next_state = twc_pkg::ST_FIN;
        end
      end
      twc_pkg::ST_FIN: begin
        next_done_flag = 1'b1;
        next_state = twc_pkg::ST_IDLE;
      end
      default: next_state = twc_pkg::ST_IDLE;
    endcase
    if (state == twc_pkg::ST_IDLE && (btn_evt || dly_evt)) begin
      next_flush_req = 1'b1;
    end
    if (next_flush_req) begin
      next_pend = 24'h000000;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= twc_pkg::ST_IDLE;
      byte_left <= 24'h000000;
      blk_left <= 24'h000000;
      pend <= 24'h000000;
      sense_key <= twc_pkg::SK_GOOD;
      asc <= 8'h00;
      ascq <= 8'h00;
      check <= 1'b0;
      done_flag <= 1'b0;
      drain_wait <= 1'b0;
      tape_wr <= 1'b0;
      tape_data <= 8'h00;
      flush_req <= 1'b0;
      logical_start_of_tape_pat_req <= 1'b0;
    end else begin
      state <= next_state;
      byte_left <= next_byte_left;
      blk_left <= next_blk_left;
      pend <= next_pend;
      sense_key <= next_sense_key;
      asc <= next_asc;
      ascq <= next_ascq;
      check <= next_check;
      done_flag <= next_done_flag;
      drain_wait <= next_drain_wait;
      tape_wr <= next_tape_wr;
      tape_data <= next_tape_data;
      flush_req <= next_flush_req;
      logical_start_of_tape_pat_req <= next_logical_start_of_tape_pat_req;
    end
  end

  // unload button filter and write delay timer
  assign tick = tick_cnt == 32'(TICK_CYC - 1);
  assign btn_evt = btn_lvl && !btn_lvl_d;
  assign dly_evt = wdelay != 8'h00 && dly_cnt == wdelay;

  always_comb begin
    next_btn_lvl = (btn_s2 == btn_s3) ? btn_s3 : btn_lvl;
    next_tick_cnt = tick ? 32'h00000000 : tick_cnt + 32'h00000001;
    next_dly_cnt = dly_cnt;
    if (pend == 24'h000000 || state != twc_pkg::ST_IDLE || flush_req
        || dly_evt) begin
      next_dly_cnt = 8'h00;
      next_tick_cnt = 32'h00000000;
    end else if (tick) begin
      next_dly_cnt = dly_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      btn_s1 <= 1'b0;
      btn_s2 <= 1'b0;
      btn_s3 <= 1'b0;
      btn_lvl <= 1'b0;
      btn_lvl_d <= 1'b0;
      tick_cnt <= 32'h00000000;
      dly_cnt <= 8'h00;
    end else begin
      btn_s1 <= unload_btn;
      btn_s2 <= btn_s1;
      btn_s3 <= btn_s2;
      btn_lvl <= next_btn_lvl;
      btn_lvl_d <= btn_lvl;
      tick_cnt <= next_tick_cnt;
      dly_cnt <= next_dly_cnt;
    end
  end
endmodule

/* File: logic/twc_pkg.sv */
// constants, register map and state type of the tape write command handler
package twc_pkg;
  // operation codes
  localparam logic [7:0] OP_WRITE = 8'h0a;
  localparam logic [7:0] OP_REWIND = 8'h01;
  localparam logic [7:0] OP_WFM = 8'h10;
  localparam logic [7:0] OP_SPACE = 8'h11;
  localparam logic [7:0] OP_ERASE = 8'h19;
  localparam logic [7:0] OP_LOAD = 8'h1b;
  localparam logic [7:0] OP_LOCATE = 8'h2b;
  // sense answers
  localparam logic [3:0] SK_GOOD = 4'h0;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_MISMATCH = 8'h81;
  localparam logic [7:0] ASCQ_MISMATCH = 8'h00;
  localparam logic [7:0] ASC_OTHER = 8'h00;
  // variable block limits in bytes: 240 and 160 kbytes
  localparam logic [23:0] VAR_MAX = 24'h03c000;
  localparam logic [23:0] VAR_MAX_ND = 24'h028000;
  // register byte addresses
  localparam logic [7:0] A_CDB0 = 8'h00;
  localparam logic [7:0] A_CDB5 = 8'h14;
  localparam logic [7:0] A_CTRL = 8'h18;
  localparam logic [7:0] A_MODEHDR = 8'h1c;
  localparam logic [7:0] A_BLKLEN = 8'h20;
  localparam logic [7:0] A_OPTS = 8'h24;
  localparam logic [7:0] A_WDELAY = 8'h28;
  localparam logic [7:0] A_MOTION = 8'h2c;
  localparam logic [7:0] A_BLKMIN = 8'h30;
  localparam logic [7:0] A_BLKMAX = 8'h34;
  localparam logic [7:0] A_STATUS = 8'h38;
  localparam logic [7:0] A_PEND = 8'h3c;
  // field positions
  localparam int CDB1_FIXED = 0;
  localparam int WFM_IMMED = 0;
  localparam int MH_BUF_LO = 4;
  localparam int MH_BUF_HI = 6;
  localparam int OPT_ND = 0;
  localparam int OPT_DISC = 1;
  localparam int OPT_NEWFMT = 2;
  localparam int OPT_PF = 3;
  localparam int CTL_GO = 0;
  localparam int CTL_LOCREV = 1;
  // reset values
  localparam logic [23:0] BLKLEN_RST = 24'h000400;
  localparam logic [23:0] MOTION_RST = 24'h080000;
  localparam logic [23:0] BLKMIN_RST = 24'h000001;
  localparam logic [23:0] BLKMAX_RST = 24'h03c000;
  localparam logic [7:0] MODEHDR_RST = 8'h10;
  localparam logic [3:0] OPTS_RST = 4'h4;
  localparam logic [7:0] WDELAY_RST = 8'h00;
  // timing: write delay counts in units of 100 ms
  localparam int CLK_KHZ = 100000;
  localparam int DELAY_UNIT_MS = 100;
  localparam int DELAY_UNIT_CYC = CLK_KHZ * DELAY_UNIT_MS;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_PATTERN,
    ST_XFER,
    ST_DRAIN,
    ST_FIN
  } twc_state_t;
endpackage

/* File: testbench/twc_write_handler_chk.sv */
// port assertions for the tape write command handler
module twc_write_handler_chk (
  input wire logic clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic reg_re, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic host_valid, // byte offered
  input wire logic [7:0] host_data, // offered byte
  input wire logic host_ready, // byte taken
  input wire logic tape_wr, // byte to buffer
  input wire logic [7:0] tape_data, // buffer byte
  input wire logic tape_full, // buffer stalls
  input wire logic tape_idle, // buffer drained
  input wire logic flush_req, // flush pulse
  input wire logic logical_start_of_tape_pat_req, // pattern request
  input wire logic pattern_done, // pattern answer
  input wire logic bus_released, // bus released
  input wire logic cmd_done // command end
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  AST_BYTE_PASSED: assert property (
    host_valid && host_ready |=> tape_wr && tape_data == $past(host_data))
    else $error("taken byte not passed on");
  AST_WR_CAUSE: assert property (
    tape_wr |-> $past(host_valid && host_ready))
    else $error("buffer write without a taken byte");
  AST_PAT_FIRST: assert property (
    logical_start_of_tape_pat_req |=> (!host_ready && !tape_wr) until_with pattern_done)
    else $error("data moved before start pattern done");
  AST_FULL_STALL: assert property (
    tape_full |-> !host_ready)
    else $error("byte taken while buffer full");
  AST_FLUSH_PULSE: assert property (
    flush_req |=> !flush_req)
    else $error("flush request longer than a cycle");
  AST_DONE_PULSE: assert property (
    cmd_done |=> !cmd_done && !host_ready)
    else $error("command end not a single pulse");
  AST_DRAIN_END: assert property (
    bus_released && $rose(tape_idle) |-> ##[1:2] cmd_done)
    else $error("drained write did not end");
  AST_RDATA_IDLE: assert property (
    !$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  cover property (logical_start_of_tape_pat_req);
  cover property (bus_released && tape_idle);
  cover property (flush_req && cmd_done);
endmodule

bind twc_write_handler twc_write_handler_chk twc_write_handler_chk_i (
  .clk, .rst_b, .reg_re, .reg_rdata, .host_valid, .host_data, .host_ready,
  .tape_wr, .tape_data, .tape_full, .tape_idle, .flush_req, .logical_start_of_tape_pat_req,
  .pattern_done, .bus_released, .cmd_done);

/* File: testbench/twc_far_model.sv */
// initiator byte source and tape buffer responder
module twc_far_model (
  input wire logic clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic host_ready, // handler takes a byte
  output logic host_valid, // byte offered
  output logic [7:0] host_data, // byte, inverted when not offered
  output logic tape_full, // buffer stalls
  output logic tape_idle, // buffer drained
  input wire logic flush_req, // flush pulse
  input wire logic logical_start_of_tape_pat_req, // pattern request
  output logic pattern_done // pattern recorded pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  int drain;
  int pat;
  assign host_data = host_valid ? cnt : ~cnt;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      host_valid <= 1'b0;
      tape_full <= 1'b0;
      tape_idle <= 1'b1;
      pattern_done <= 1'b0;
      drain <= 0;
      pat <= 0;
    end else begin
      if (host_valid && host_ready) cnt <= cnt + 8'h01;
      // an offered byte stays until taken
      host_valid <= (host_valid && !host_ready) || $urandom_range(3, 0) != 0;
      tape_full <= $urandom_range(5, 0) == 0;
      if (flush_req) begin
        tape_idle <= 1'b0;
        drain <= $urandom_range(9, 2);
      end else if (drain > 1) drain <= drain - 1;
      else if (drain == 1) begin
        drain <= 0;
        tape_idle <= 1'b1;
      end
      pattern_done <= pat == 1;
      if (logical_start_of_tape_pat_req) pat <= $urandom_range(6, 2);
      else if (pat > 0) pat <= pat - 1;
    end
  end
endmodule

/* File: testbench/twc_tb_top.sv */
// random write commands checked against a behavioural model
module tape_write_command_handler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, reg_we = 0, reg_re = 0, unload_btn = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic host_valid, host_ready, tape_wr, tape_full, tape_idle, flush_req;
  logic logical_start_of_tape_pat_req, pattern_done, bus_released, cmd_done;
  logic [7:0] host_data, tape_data;
  logic [4:0] pos = 5'h00;
  logic [1:0] cart = 2'h0;
  int miscompares = 0, check_count = 0, nbytes = 0, nflush = 0, cyc = 0;

  twc_write_handler #(.TICK_CYC(4)) twc_write_handler_i (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .host_valid, .host_data, .host_ready, .tape_wr, .tape_data, .tape_full,
    .tape_idle, .flush_req, .logical_start_of_tape_pat_req, .pattern_done, .pos_logical_start_of_tape(pos[0]),
    .pos_fm_bot(pos[1]), .pos_fm_eot(pos[2]), .pos_eod(pos[3]),
    .pos_blank(pos[4]), .cart_fmt_known(cart[0]), .cart_fmt_new(cart[1]),
    .unload_btn, .bus_released, .cmd_done);
  twc_far_model twc_far_model_i (.clk, .rst_b, .host_ready, .host_valid,
    .host_data, .tape_full, .tape_idle, .flush_req, .logical_start_of_tape_pat_req,
    .pattern_done);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (tape_wr) nbytes++;
    if (flush_req) nflush++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cmd(input logic [7:0] op, b1, input int len, input logic rev,
                     output logic [31:0] st);
    int k;
    wr(8'h00, {24'h0, op});
    wr(8'h04, {24'h0, b1});
    for (k = 0; k < 3; k++) wr(8'(4 * k + 8), {24'h0, 8'(len >> (16 - 8 * k))});
    wr(twc_pkg::A_CTRL, {30'h0, rev, 1'b1});
    k = 0;
    #1;
    while (!cmd_done && k < 2000) begin
      @(posedge clk);
      #1 k++;
    end
    chk("done", 32'h1, {31'h0, cmd_done});
    rd(twc_pkg::A_STATUS, st);
  endtask

  task automatic run(input logic fx, input int bl, input logic [3:0] opt,
                     input logic bm, input int len);
    int b0, f0, exn;
    logic [31:0] st;
    logic [3:0] sk;
    logic [7:0] asc;
    wr(twc_pkg::A_BLKLEN, 32'(bl));
    wr(twc_pkg::A_OPTS, {28'h0, opt});
    wr(twc_pkg::A_MODEHDR, bm ? {25'h0, 3'($urandom_range(7, 1)), 4'h0} : 0);
    sk = 4'h0;
    asc = 8'h00;
    exn = 0;
    if (fx != (bl != 0)) begin
      sk = 4'h5;
      asc = 8'h81;
    end else if (fx ? (bl < 2 || bl > 4) : len > (opt[0] ? 163840 : 245760))
      sk = 4'h5;
    else if (!(pos[0] || (opt[2] ? |pos[3:1] : pos[1] | pos[4])))
      sk = 4'h5;
    else if (!pos[0] && cart[0] && cart[1] != opt[2]) sk = 4'h5;
    else exn = fx ? len * bl : len;
    b0 = nbytes;
    f0 = nflush;
    cmd(8'h0a, {7'h0, fx}, len, 1'b0, st);
    chk("status", {8'h00, asc, sk, 9'h0, 1'b1, sk != 4'h0, 1'b0}, st);
    chk("bytes", exn, nbytes - b0);
    chk("flushes", {31'h0, exn > 0 && !bm}, nflush - f0);
  endtask

  initial begin
    logic [31:0] v, st;
    int i, len;
    logic fx;
    logic [3:0] opt;
    logic [7:0] ra[8] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h40};
    logic [31:0] rv[8] = '{32'h10, 32'h400, 32'h4, 0, 32'h80000, 1, 32'h3c000, 0};
    logic [7:0] fo[8] = '{8'h01, 8'h10, 8'h10, 8'h11, 8'h19, 8'h1b, 8'h2b, 8'h2b};
    logic [7:0] fb = 8'b00000100;
    logic [7:0] fr = 8'b01000000;
    logic [7:0] fe = 8'b01111011;
    int bt[5] = '{0, 1, 2, 4, 5};
    void'($urandom(19716));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(ra[i], v);
      chk("reset value", rv[i], v);
    end
    wr(twc_pkg::A_BLKMIN, 32'h2);
    wr(twc_pkg::A_BLKMAX, 32'h4);
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      pos <= 5'($urandom);
      cart <= 2'($urandom);
      fx = 1'($urandom);
      opt = 4'($urandom);
      len = $urandom_range(3, 0);
      if (!fx && $urandom_range(3, 0) == 0) len = opt[0] ? 163841 : 245761;
      run(fx, bt[$urandom_range(4, 0)], opt, 1'($urandom), len);
    end
    for (i = 0; i < 8; i++) begin
      v = nflush;
      cmd(fo[i], {7'h0, fb[i]}, 0, fr[i], st);
      chk("command flush", {31'h0, fe[i]}, nflush - v);
    end
    v = nflush;
    @(posedge clk);
    unload_btn <= 1'b1;
    repeat (8) @(posedge clk);
    unload_btn <= 1'b0;
    #1 chk("button flush", 32'h1, nflush - v);
    wr(twc_pkg::A_OPTS, 32'h4);
    wr(twc_pkg::A_WDELAY, 32'h3);
    rd(twc_pkg::A_WDELAY, v);
    chk("delay refused", 32'h0, v);
    wr(twc_pkg::A_OPTS, 32'h8);
    wr(twc_pkg::A_WDELAY, 32'h2);
    rd(twc_pkg::A_WDELAY, v);
    chk("delay taken", 32'h2, v);
    @(posedge clk);
    pos <= 5'h02;
    cart <= 2'h0;
    for (i = 0; i < 2; i++) begin
      run(1'b0, 0, 4'h8, 1'b1, 3);
      v = nflush;
      repeat (30) @(posedge clk);
      #1 chk("timed flush", {31'h0, i == 0}, nflush - v);
      wr(twc_pkg::A_WDELAY, 32'h0);
    end
    end_of_test();
  end
endmodule
